// [sim/continuous_trigger_control_tb.sv]
// bench for the continuous trigger control block
// assumes ctc_pkg and the measurement engine model are compiled first
`default_nettype none

module continuous_trigger_control_tb import ctc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic remote_active = 1'b0;
    logic trig_source = CTC_SRC_EXT;
    logic trig_pin = 1'b0;
    logic key_trig = 1'b0;
    logic bus_trig = 1'b0;
    logic meas_done, meas_start, setting, query_valid, query_on, trig_idle, trig_waiting;
    ctc_req_t req = '{1'b0, CTC_CMD_NONE, 1'b0};
    logic [3:0] lat = 4'h1;
    logic [31:0] seed = 32'h29;
    int mismatches = 0;
    int samples_checked = 0;
    int starts = 0;
    int s0;

    ctc_continuous_trigger DUT (.clk_sys(clk_sys), .rst(rst), .req(req),
        .remote_active(remote_active), .trig_source(trig_source), .trig_pin(trig_pin),
        .key_trig(key_trig), .bus_trig(bus_trig), .meas_done(meas_done),
        .meas_start(meas_start), .rearm_after_measure_setting(setting),
        .query_valid(query_valid), .query_on(query_on), .trig_idle(trig_idle),
        .trig_waiting(trig_waiting));
    ctc_meas_model u_meas (.clk_sys(clk_sys), .rst(rst), .meas_start(meas_start),
        .lat(lat), .meas_done(meas_done));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (meas_start === 1'b1) starts <= starts + 1;

    // ==========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // disabled setting ends a measurement in idle
    function automatic logic exp_idle(input logic on);
        return !on;
    endfunction

    task automatic chk(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_n(input string nm, input int e, input int g);
        samples_checked++;
        if (g != e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic cmd(input ctc_cmd_t c, input logic v);
        @(posedge clk_sys);
        req <= '{1'b1, c, v};
        @(posedge clk_sys);
        req <= '{1'b0, CTC_CMD_NONE, 1'b0};
        #1;
    endtask

    // kind 0 pin, 1 key, 2 bus; pin held long enough for the synchroniser
    task automatic fire(input int k);
        @(posedge clk_sys);
        trig_pin <= (k == 0);
        key_trig <= (k == 1);
        bus_trig <= (k == 2);
        @(posedge clk_sys);
        key_trig <= 1'b0;
        bus_trig <= 1'b0;
        repeat (4) @(posedge clk_sys);
        trig_pin <= 1'b0;
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end

    // ==========================================
    // scenarios
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("setting", 1'b1, setting);
        chk("waiting", 1'b1, trig_waiting);
        chk("idle", 1'b0, trig_idle);
        cmd(CTC_CMD_QUERY, 1'b0);
        chk("query_valid", 1'b1, query_valid);
        chk("query_on", 1'b1, query_on);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            @(posedge clk_sys);
            lat <= seed[3:0];
            s0 = starts;
            fire(seed[5:4] % 3);
            tick(40);
            chk_n("starts", 1, starts - s0);
            chk("waiting", 1'b1, trig_waiting);
        end
        cmd(CTC_CMD_SET, CTC_SET_OFF);
        tick(2);
        chk("local_set", 1'b1, setting);
        @(posedge clk_sys);
        remote_active <= 1'b1;
        cmd(CTC_CMD_SET, CTC_SET_OFF);
        tick(2);
        chk("set_off", CTC_SET_OFF, setting);
        cmd(CTC_CMD_QUERY, 1'b0);
        chk("query_on", 1'b0, query_on);
        s0 = starts;
        fire(2);
        tick(40);
        chk("idle", exp_idle(CTC_SET_OFF), trig_idle);
        fire(0);
        fire(1);
        fire(2);
        tick(40);
        chk_n("starts", 1, starts - s0);
        cmd(CTC_CMD_ARM, 1'b0);
        tick(1);
        chk("armed", 1'b1, trig_waiting);
        fire(0);
        tick(40);
        chk_n("starts", 2, starts - s0);
        chk("idle", exp_idle(CTC_SET_OFF), trig_idle);
        @(posedge clk_sys);
        trig_source <= CTC_SRC_IMM;
        cmd(CTC_CMD_ARM, 1'b0);
        tick(40);
        chk_n("starts", 3, starts - s0);
        chk("idle", 1'b1, trig_idle);
        @(posedge clk_sys);
        lat <= 4'h1;
        cmd(CTC_CMD_SET, CTC_SET_ON);
        tick(2);
        chk("set_on", CTC_SET_ON, setting);
        s0 = starts;
        cmd(CTC_CMD_ARM, 1'b0);
        tick(40);
        chk("free_run", 1'b1, (starts - s0) > 3);
        @(posedge clk_sys);
        trig_source <= CTC_SRC_EXT;
        tick(40);
        chk("waiting", 1'b1, trig_waiting);
        cmd(CTC_CMD_SET, CTC_SET_OFF);
        @(posedge clk_sys);
        remote_active <= 1'b0;
        tick(3);
        chk("local_exit", 1'b1, setting);
        final_report();
    end
endmodule

`default_nettype wire

// [sim/ctc_meas_model.sv]
// measurement engine model: answers each start pulse with a done pulse
// assumes start is a one-cycle pulse on clk_sys; lat sets a prompt or slow answer
`default_nettype none

module ctc_meas_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // handshake
    input wire logic meas_start,
    input wire logic [3:0] lat,
    output logic meas_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    logic busy_r;

    always_ff @(posedge clk_sys)
    begin
        meas_done <= 1'b0;
        if (rst)
        begin
            busy_r <= 1'b0;
        end
        else if (meas_start)
        begin
            busy_r <= 1'b1;
            cnt_r <= lat;
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h0)
            begin
                busy_r <= 1'b0;
                meas_done <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// [src/ctc_continuous_trigger.sv]
// continuous trigger control: re-arm setting, arm command and trigger state
// assumes host command decoder and measurement engine on the same clock;
// the trigger pin arrives asynchronously and is synchronised here
`default_nettype none

module ctc_continuous_trigger
    import ctc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host commands
    input wire ctc_req_t req,
    input wire logic remote_active,
    input wire logic trig_source,
    // triggers
    input wire logic trig_pin,
    input wire logic key_trig,
    input wire logic bus_trig,
    // measurement engine
    input wire logic meas_done,
    // results
    output logic meas_start,
    output logic rearm_after_measure_setting,
    output logic query_valid,
    output logic query_on,
    output logic trig_idle,
    output logic trig_waiting
);

    // ==========================================
    // trigger pin synchroniser
    logic [2:0] pin_sync_r;
    logic [2:0] pin_sync_nxt;
    logic pin_level_r;
    logic pin_level_nxt;
    logic pin_edge;

    always_comb
    begin
        pin_sync_nxt = {pin_sync_r[1:0], trig_pin};
        pin_level_nxt = pin_level_r;
        if (pin_sync_r[1] == pin_sync_r[2])
        begin
            pin_level_nxt = pin_sync_r[2];
        end
    end

    assign pin_edge = pin_level_nxt & ~pin_level_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_sync_r <= 3'h0;
            pin_level_r <= 1'h0;
        end
        else
        begin
            pin_sync_r <= pin_sync_nxt;
            pin_level_r <= pin_level_nxt;
        end
    end

    // ==========================================
    // setting, state and outputs
    ctc_state_t state_r;
    ctc_state_t state_nxt;
    logic setting_r;
    logic setting_nxt;
    logic remote_r;
    logic start_r;
    logic start_nxt;
    logic qv_r;
    logic qv_nxt;
    logic qon_r;
    logic qon_nxt;
    logic ext_trig;
    logic arm;
    logic fire;

    assign ext_trig = pin_edge | key_trig | bus_trig;
    assign arm = req.valid && (req.cmd == CTC_CMD_ARM);
    assign fire = (trig_source == CTC_SRC_IMM) || ext_trig;

    always_comb
    begin
        setting_nxt = setting_r;
        state_nxt = state_r;
        start_nxt = 1'h0;
        qv_nxt = 1'h0;
        qon_nxt = qon_r;
        if (req.valid && (req.cmd == CTC_CMD_SET) && remote_active)
        begin
            setting_nxt = (req.value == CTC_SET_ON);
        end
        if (remote_r && !remote_active)
        begin
            setting_nxt = CTC_SET_ON;
        end
        if (req.valid && (req.cmd == CTC_CMD_QUERY))
        begin
            qv_nxt = 1'h1;
            qon_nxt = setting_r;
        end
        case (state_r)
            CTC_ST_IDLE:
            begin
                if (arm)
                begin
                    state_nxt = CTC_ST_WAIT;
                end
            end
            CTC_ST_WAIT:
            begin
                if (fire)
                begin
                    state_nxt = CTC_ST_MEAS;
                    start_nxt = 1'h1;
                end
            end
            CTC_ST_MEAS:
            begin
                if (meas_done)
                begin
                    state_nxt = setting_r ? CTC_ST_WAIT : CTC_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = CTC_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            setting_r <= CTC_SET_RST;
            state_r <= CTC_ST_WAIT;
            remote_r <= 1'h0;
            start_r <= 1'h0;
            qv_r <= 1'h0;
            qon_r <= 1'h0;
        end
        else
        begin
            setting_r <= setting_nxt;
            state_r <= state_nxt;
            remote_r <= remote_active;
            start_r <= start_nxt;
            qv_r <= qv_nxt;
            qon_r <= qon_nxt;
        end
    end

    // ==========================================
    // outputs straight from flip-flops
    logic idle_r;
    logic wait_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            idle_r <= 1'h0;
            wait_r <= 1'h1;
        end
        else
        begin
            idle_r <= (state_nxt == CTC_ST_IDLE);
            wait_r <= (state_nxt == CTC_ST_WAIT);
        end
    end

    assign meas_start = start_r;
    assign rearm_after_measure_setting = setting_r;
    assign query_valid = qv_r;
    assign query_on = qon_r;
    assign trig_idle = idle_r;
    assign trig_waiting = wait_r;

    // ==========================================
    // assertions
    sequence s_done_in_meas;
        (state_r == CTC_ST_MEAS) && meas_done;
    endsequence

    property p_rearm;
        @(posedge clk_sys) disable iff (rst)
        s_done_in_meas ##0 setting_r |=> trig_waiting;
    endproperty
    a_rearm: assert property (p_rearm) else $error("no rearm");

    property p_to_idle;
        @(posedge clk_sys) disable iff (rst)
        s_done_in_meas ##0 !setting_r |=> trig_idle;
    endproperty
    a_to_idle: assert property (p_to_idle) else $error("no idle");

    property p_free_run;
        @(posedge clk_sys) disable iff (rst)
        (state_r == CTC_ST_WAIT) && (trig_source == CTC_SRC_IMM) |=> meas_start;
    endproperty
    a_free_run: assert property (p_free_run) else $error("no fire");

    property p_idle_ignore;
        @(posedge clk_sys) disable iff (rst)
        (state_r == CTC_ST_IDLE) |=> !meas_start;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("idle start");

    property p_arm;
        @(posedge clk_sys) disable iff (rst)
        (state_r == CTC_ST_IDLE) && arm |=> trig_waiting;
    endproperty
    a_arm: assert property (p_arm) else $error("arm lost");

    property p_local_on;
        @(posedge clk_sys) disable iff (rst)
        $fell(remote_active) |=> ##1 rearm_after_measure_setting;
    endproperty
    a_local_on: assert property (p_local_on) else $error("not forced");

    property p_local_no_off;
        @(posedge clk_sys) disable iff (rst)
        !remote_active && setting_r |=> setting_r;
    endproperty
    a_local_no_off: assert property (p_local_no_off) else $error("local off");

    property p_query;
        @(posedge clk_sys) disable iff (rst)
        req.valid && (req.cmd == CTC_CMD_QUERY) |=> query_valid && (query_on == $past(setting_r));
    endproperty
    a_query: assert property (p_query) else $error("bad query");

    property p_ext;
        @(posedge clk_sys) disable iff (rst)
        (state_r == CTC_ST_WAIT) && (key_trig || bus_trig) |=> meas_start;
    endproperty
    a_ext: assert property (p_ext) else $error("trig lost");

endmodule

`default_nettype wire

// [src/ctc_pkg.sv]
// package for the continuous trigger control block: constants, types, commands
// assumes a single 100 MHz clock and a synchronous active-high reset
// Function
// - setting value 1/ON enables, 0/OFF disables
// - query reports current setting as ON/OFF
// - enabled setting returns to trigger wait
// - enabled plus immediate source triggers at once
// - disabled setting ends measurement in idle
// - idle ignores every trigger event
// - arm command moves idle to trigger wait
// - leaving remote forces setting enabled
// - key, bus trigger equal external trigger
// - only remote commands may disable setting
// - disabled, immediate: arm gives one measurement
`default_nettype none

package ctc_pkg;

    // ==========================================
    // setting encodings and reset values
    localparam logic CTC_SET_ON = 1'h1;
    localparam logic CTC_SET_OFF = 1'h0;
    localparam logic CTC_SET_RST = CTC_SET_ON;
    localparam logic CTC_SRC_IMM = 1'h0;
    localparam logic CTC_SRC_EXT = 1'h1;

    // ==========================================
    // host command codes
    typedef enum logic [1:0]
    {
        CTC_CMD_SET = 2'h0,
        CTC_CMD_QUERY = 2'h1,
        CTC_CMD_ARM = 2'h2,
        CTC_CMD_NONE = 2'h3
    } ctc_cmd_t;

    // ==========================================
    // trigger logic states
    typedef enum logic [1:0]
    {
        CTC_ST_IDLE = 2'h0,
        CTC_ST_WAIT = 2'h1,
        CTC_ST_MEAS = 2'h2
    } ctc_state_t;

    // command strobe from the remote interface
    typedef struct packed
    {
        logic valid;
        ctc_cmd_t cmd;
        logic value;
    } ctc_req_t;

    // trigger sources that all count as an external trigger
    typedef struct packed
    {
        logic pin_trig;
        logic key_trig;
        logic bus_trig;
    } ctc_trig_t;

endpackage

`default_nettype wire
